//--- verilog/fpe_top.sv
// Our own choice: register access over APB.
`timescale 1ns/1ps
module fpe_top #(
  parameter bit LARGE_FLASH = 1'b1
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire fpe_pkg::fpe_seq_evt_t SEQ_EVT,
  input wire logic STANDBY_ENTRY,
  output logic PE_ENABLE,
  output logic BLANK_CHECK_ENABLE,
  output logic CMD_LOCKED,
  output logic ILLEGAL_ERROR,
  output logic IRQ
);
  import fpe_pkg::*;

  localparam logic [7:0] IEN_RST = LARGE_FLASH ? IEN_RST_LARGE : IEN_RST_SMALL;
  localparam fpe_state_t STATE_RST = '{
    prot: PROT_RST, cviol: 1'b0, dviol: 1'b0, lock: 1'b0, arm_c: 1'b0, arm_d: 1'b0,
    ien_c: IEN_RST[CFLASH_BIT], ien_l: IEN_RST[LOCK_BIT], ien_d: IEN_RST[DFLASH_BIT],
    pe_en: (PROT_RST == ENF_ON), bc_en: LARGE_FLASH && (PROT_RST == ENF_ON),
    illegal: 1'b0, irq: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: 32'h0};

  fpe_state_t q;
  fpe_state_t d;
  fpe_sel_t sel;
  logic acc_first;
  logic acc_done;
  logic wr_prot;
  logic wr_stat;
  logic wr_ien;
  logic rd_stat;
  logic cv_set;
  logic dv_set;
  logic lock_set;
  logic clr_cmd;

  // address decode for the three registers
  function automatic fpe_sel_t fpe_decode(input logic [31:0] addr);
    if (addr == PROT_ADDR) begin
      fpe_decode = SEL_PROT;
    end else if (addr == STAT_ADDR) begin
      fpe_decode = SEL_STAT;
    end else if (addr == IEN_ADDR) begin
      fpe_decode = SEL_IEN;
    end else begin
      fpe_decode = SEL_NONE;
    end
  endfunction

  // status register image, reserved bits zero
  function automatic logic [7:0] fpe_stat_img(input fpe_state_t s);
    fpe_stat_img = 8'h00;
    fpe_stat_img[CFLASH_BIT] = s.cviol;
    fpe_stat_img[LOCK_BIT] = s.lock;
    fpe_stat_img[DFLASH_BIT] = s.dviol;
  endfunction

  // interrupt enable image, reserved bits zero
  function automatic logic [7:0] fpe_ien_img(input fpe_state_t s);
    fpe_ien_img = 8'h00;
    fpe_ien_img[CFLASH_BIT] = s.ien_c;
    fpe_ien_img[LOCK_BIT] = s.ien_l;
    fpe_ien_img[DFLASH_BIT] = s.ien_d;
  endfunction

  // bus phase and event qualifiers
  always_comb begin
    sel = fpe_decode(PADDR);
    acc_first = PSEL && PENABLE && !q.pready;
    acc_done = PSEL && PENABLE && q.pready;
    wr_prot = acc_done && PWRITE && PSTRB[0] && (sel == SEL_PROT);
    wr_stat = acc_done && PWRITE && PSTRB[0] && (sel == SEL_STAT);
    wr_ien = acc_done && PWRITE && PSTRB[0] && (sel == SEL_IEN);
    rd_stat = acc_done && !PWRITE && (sel == SEL_STAT);
    cv_set = SEQ_EVT.code_viol;
    dv_set = SEQ_EVT.data_viol && LARGE_FLASH;
    lock_set = cv_set || dv_set || SEQ_EVT.prot_err;
    clr_cmd = SEQ_EVT.stat_clr || SEQ_EVT.force_stop;
  end

  // next state
  always_comb begin
    d = q;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    // protect register, reserved bits dropped on write
    if (STANDBY_ENTRY) begin
      d.prot = PROT_RST;
    end else if (wr_prot) begin
      d.prot = PWDATA[ENF_LSB +: 2];
    end
    d.pe_en = (d.prot == ENF_ON);
    d.bc_en = LARGE_FLASH && (d.prot == ENF_ON);
    // read of one arms the write-zero clear; any status write disarms
    if (rd_stat) begin
      d.arm_c = q.arm_c || q.cviol;
      d.arm_d = q.arm_d || q.dviol;
    end
    if (wr_stat) begin
      d.arm_c = 1'b0;
      d.arm_d = 1'b0;
    end
    // code flash violation flag, set wins over every clear
    if (cv_set) begin
      d.cviol = 1'b1;
    end else if (clr_cmd) begin
      d.cviol = 1'b0;
      d.arm_c = 1'b0;
    end else if (wr_stat && !PWDATA[CFLASH_BIT] && q.arm_c) begin
      d.cviol = 1'b0;
    end
    // data flash violation flag
    if (dv_set) begin
      d.dviol = 1'b1;
    end else if (clr_cmd) begin
      d.dviol = 1'b0;
      d.arm_d = 1'b0;
    end else if (wr_stat && !PWDATA[DFLASH_BIT] && q.arm_d) begin
      d.dviol = 1'b0;
    end
    // command lock, not writable from the bus
    if (lock_set) begin
      d.lock = 1'b1;
    end else if (clr_cmd) begin
      d.lock = 1'b0;
    end
    d.illegal = cv_set || dv_set;
    // interrupt enables; small variant keeps the data enable at one
    if (wr_ien) begin
      d.ien_c = PWDATA[CFLASH_BIT];
      d.ien_l = PWDATA[LOCK_BIT];
      d.ien_d = LARGE_FLASH ? PWDATA[DFLASH_BIT] : 1'b1;
    end
    d.irq = (d.cviol && d.ien_c) || (d.lock && d.ien_l) || (d.dviol && d.ien_d);
    // one wait state: read data captured in the first access cycle
    if (acc_first) begin
      d.pready = 1'b1;
      d.pslverr = (sel == SEL_NONE);
      case (sel)
        SEL_PROT: d.prdata = {30'h0, q.prot};
        SEL_STAT: d.prdata = {24'h0, fpe_stat_img(q)};
        SEL_IEN: d.prdata = {24'h0, fpe_ien_img(q)};
        default: d.prdata = 32'h0;
      endcase
    end
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      q <= STATE_RST;
    end else if (CE) begin
      q <= d;
    end
  end

  // outputs straight from the state flops
  assign PRDATA = q.prdata;
  assign PREADY = q.pready;
  assign PSLVERR = q.pslverr;
  assign PE_ENABLE = q.pe_en;
  assign BLANK_CHECK_ENABLE = q.bc_en;
  assign CMD_LOCKED = q.lock;
  assign ILLEGAL_ERROR = q.illegal;
  assign IRQ = q.irq;

  // checks on the driven state
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);

  sequence s_status_read_one;
    CE && rd_stat && q.cviol && !cv_set && !clr_cmd;
  endsequence

  sequence s_violation_event;
    CE && (cv_set || dv_set);
  endsequence

  sequence s_status_write_zero;
    CE && wr_stat && !PWDATA[CFLASH_BIT] && !cv_set && !clr_cmd;
  endsequence

  a_pe_gate_map: assert property (CE |=> PE_ENABLE == (q.prot == ENF_ON))
    else $error("program enable does not follow enable field");

  a_blank_check_gate: assert property (BLANK_CHECK_ENABLE == (LARGE_FLASH && PE_ENABLE))
    else $error("blank check enable wrong for variant");

  a_standby_restore: assert property (CE && STANDBY_ENTRY |=> q.prot == PROT_RST && PE_ENABLE)
    else $error("standby entry did not restore protect value");

  a_prot_reserved_zero: assert property (PREADY && $past(sel) == SEL_PROT |-> PRDATA[31:2] == 30'h0)
    else $error("protect reserved bits read nonzero");

  a_lock_on_violation: assert property (CE && (cv_set || dv_set) |=> CMD_LOCKED && ILLEGAL_ERROR)
    else $error("violation did not lock or flag illegal error");

  a_illegal_one_pulse: assert property (ILLEGAL_ERROR && CE && !cv_set && !dv_set |=> !ILLEGAL_ERROR)
    else $error("illegal error pulse too long");

  a_read_then_clear: assert property (s_status_write_zero and (q.cviol && q.arm_c)
    |=> !q.cviol)
    else $error("write zero after read one did not clear flag");

  a_no_blind_clear: assert property (s_status_write_zero and (q.cviol && !q.arm_c) |=> q.cviol)
    else $error("flag cleared without prior read");

  a_write_one_keeps: assert property (CE && wr_stat && PWDATA[CFLASH_BIT] && q.cviol |=> q.cviol)
    else $error("writing one cleared the flag");

  // a status read that sees the flag set arms the clear
  a_read_arms: assert property (s_status_read_one |=> q.arm_c)
    else $error("read of one did not arm the clear");

  // any status write uses up the arming
  a_write_disarms: assert property (CE && wr_stat |=> !q.arm_c && !q.arm_d)
    else $error("status write left the clear armed");

  // data flag follows the same read-then-write-zero clear
  a_dflag_clear: assert property (CE && wr_stat && !PWDATA[DFLASH_BIT] && q.arm_d && !dv_set |=> !q.dviol)
    else $error("data flag not cleared after read one");

  // the bus cannot move the lock bit
  a_lock_not_written: assert property (CE && wr_stat && !lock_set && !clr_cmd |=> CMD_LOCKED == $past(CMD_LOCKED))
    else $error("status write changed the lock");

  // non-violation protection errors lock too
  a_prot_err_locks: assert property (CE && SEQ_EVT.prot_err |=> CMD_LOCKED)
    else $error("protection error did not lock");

  // a violation raises its flag and the illegal pulse together
  a_violation_flags: assert property (s_violation_event |=> ILLEGAL_ERROR && (q.cviol || q.dviol))
    else $error("violation flag or illegal pulse missing");

  // status reserved bits read zero
  a_stat_reserved: assert property (PREADY && $past(sel) == SEL_STAT |-> PRDATA[31:8] == 24'h0 && PRDATA[6:5] == 2'h0 && PRDATA[2:0] == 3'h0)
    else $error("status reserved bits read nonzero");

  // enable reserved bits read zero
  a_ien_reserved: assert property (PREADY && $past(sel) == SEL_IEN |-> PRDATA[31:8] == 24'h0 && PRDATA[6:5] == 2'h0 && PRDATA[2:0] == 3'h0)
    else $error("enable reserved bits read nonzero");

  // small variant never offers blank checking
  a_small_no_blank: assert property (!LARGE_FLASH |-> !BLANK_CHECK_ENABLE)
    else $error("blank check enabled on small variant");

  // standby entry beats a protect write in the same cycle
  a_standby_priority: assert property (CE && STANDBY_ENTRY && wr_prot |=> q.prot == PROT_RST)
    else $error("protect write beat standby entry");

  // a violation wins over a clear command in the same cycle
  a_set_beats_clear: assert property (CE && cv_set && clr_cmd |=> q.cviol && CMD_LOCKED)
    else $error("clear command beat a violation");

  // after a clean clear nothing is left to interrupt
  a_clear_drops_irq: assert property (CE && clr_cmd && !lock_set |=> !IRQ)
    else $error("interrupt stayed after clear command");

  // the request needs at least one flag behind it
  a_irq_needs_flag: assert property (IRQ |-> q.cviol || q.lock || q.dviol)
    else $error("interrupt without any flag");

  a_cmd_releases: assert property (CE && clr_cmd && !lock_set
    |=> !CMD_LOCKED && !q.cviol && !q.dviol)
    else $error("clear command did not release lock and flags");

  a_lock_holds: assert property (CMD_LOCKED && !(CE && clr_cmd) |=> CMD_LOCKED)
    else $error("lock released without a clear command");

  a_irq_pairs: assert property (CE |=> IRQ == ((q.cviol && q.ien_c) || (q.lock && q.ien_l)
    || (q.dviol && q.ien_d)))
    else $error("interrupt does not match flag and enable pairs");

  a_small_reserved: assert property (!LARGE_FLASH |-> !q.dviol && q.ien_d)
    else $error("small variant data flag or enable wrong");

endmodule

//--- common/fpe_pkg.sv
package fpe_pkg;
  // register indices and byte addresses (byte address is four times the index)
  localparam logic [31:0] PROT_IDX = 32'h0008c296;
  localparam logic [31:0] STAT_IDX = 32'h0008c297;
  localparam logic [31:0] IEN_IDX = 32'h0008c298;
  localparam logic [31:0] PROT_ADDR = PROT_IDX * 32'h4;
  localparam logic [31:0] STAT_ADDR = STAT_IDX * 32'h4;
  localparam logic [31:0] IEN_ADDR = IEN_IDX * 32'h4;
  // field positions
  localparam int ENF_LSB = 0;
  localparam int DFLASH_BIT = 3;
  localparam int LOCK_BIT = 4;
  localparam int CFLASH_BIT = 7;
  // field values and reset values
  localparam logic [1:0] ENF_ON = 2'h1;
  localparam logic [1:0] PROT_RST = 2'h1;
  localparam logic [7:0] IEN_RST_LARGE = 8'h00;
  localparam logic [7:0] IEN_RST_SMALL = 8'h08;
  // register select codes
  typedef enum logic [1:0] {SEL_NONE, SEL_PROT, SEL_STAT, SEL_IEN} fpe_sel_t;
  // events from the sequencer core, one-cycle pulses
  typedef struct packed {
    logic code_viol;
    logic data_viol;
    logic prot_err;
    logic stat_clr;
    logic force_stop;
  } fpe_seq_evt_t;
  // whole state of the block
  typedef struct packed {
    logic [1:0] prot;
    logic cviol;
    logic dviol;
    logic lock;
    logic arm_c;
    logic arm_d;
    logic ien_c;
    logic ien_l;
    logic ien_d;
    logic pe_en;
    logic bc_en;
    logic illegal;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } fpe_state_t;
endpackage

//--- tb/fpe_seq_model.sv
`timescale 1ns/1ps
// sequencer core stand-in: registers the bench request onto the event lines, one cycle later
module fpe_seq_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [4:0] req,
  output fpe_pkg::fpe_seq_evt_t evt
);
  import fpe_pkg::*;
  // stat_clr and force_stop are the only ways out of the lock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      evt <= '0;
    end else begin
      evt <= req;
    end
  end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import fpe_pkg::*;
  logic CLK, ARST_N, CE, PSEL, PENABLE, PWRITE, STANDBY_ENTRY;
  logic [31:0] PADDR, PWDATA, PRDATA, r;
  logic PREADY, PSLVERR, PE_ENABLE, BLANK_CHECK_ENABLE, CMD_LOCKED, ILLEGAL_ERROR, IRQ, x;
  logic [4:0] req;
  fpe_seq_evt_t seq_evt;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  fpe_top i_fpe_top (.CLK(CLK), .ARST_N(ARST_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(4'h1), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .SEQ_EVT(seq_evt), .STANDBY_ENTRY(STANDBY_ENTRY),
    .PE_ENABLE(PE_ENABLE), .BLANK_CHECK_ENABLE(BLANK_CHECK_ENABLE), .CMD_LOCKED(CMD_LOCKED),
    .ILLEGAL_ERROR(ILLEGAL_ERROR), .IRQ(IRQ));
  fpe_seq_model i_fpe_seq_model (.clk(CLK), .arst_n(ARST_N), .req(req), .evt(seq_evt));
  // clock generator
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // verdict and end of run
  task summarize();
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, held until pready is seen high or 50 cycles pass
  task apb(input logic w, input logic [31:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h000000, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (PREADY !== 1'b1) chk("pready", 32'h1, {31'h0, PREADY});
    r = PRDATA;
    x = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    #1;
  endtask
  task rd(input logic [31:0] a, input string nm, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(nm, {24'h000000, e}, r);
  endtask
  // request events, return once the block has answered
  task ev(input logic [4:0] v);
    @(posedge CLK);
    req <= v;
    @(posedge CLK);
    req <= 5'h00;
    @(posedge CLK);
    #1;
  endtask
  // hang guard
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      summarize();
    end
  end
  // main sequence
  initial begin
    ARST_N = 1'b0;
    CE = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 32'h0;
    PWDATA = 32'h0;
    STANDBY_ENTRY = 1'b0;
    req = 5'h00;
    repeat (20) @(posedge CLK);
    ARST_N <= 1'b1;
    rd(PROT_ADDR, "prot", 8'h01);
    rd(IEN_ADDR, "ien", 8'h00);
    rd(STAT_ADDR, "stat", 8'h00);
    for (int v = 0; v < 4; v++) begin
      apb(1'b1, PROT_ADDR, 8'(v));
      rd(PROT_ADDR, "prot", 8'(v));
      chk("pe_en", {31'h0, v == 1}, {31'h0, PE_ENABLE});
      chk("bc_en", {31'h0, v == 1}, {31'h0, BLANK_CHECK_ENABLE});
    end
    @(posedge CLK);
    STANDBY_ENTRY <= 1'b1;
    @(posedge CLK);
    STANDBY_ENTRY <= 1'b0;
    rd(PROT_ADDR, "prot", 8'h01);
    apb(1'b1, IEN_ADDR, 8'h98);
    rd(IEN_ADDR, "ien", 8'h98);
    ev(5'h10);
    chk("lock", 1, {31'h0, CMD_LOCKED});
    chk("illegal", 1, {31'h0, ILLEGAL_ERROR});
    chk("irq", 1, {31'h0, IRQ});
    @(posedge CLK);
    #1;
    chk("illegal", 0, {31'h0, ILLEGAL_ERROR});
    rd(STAT_ADDR, "stat", 8'h90);
    apb(1'b1, STAT_ADDR, 8'h90);
    apb(1'b1, STAT_ADDR, 8'h00);
    rd(STAT_ADDR, "stat", 8'h90);
    apb(1'b1, STAT_ADDR, 8'h00);
    rd(STAT_ADDR, "stat", 8'h10);
    chk("irq", 1, {31'h0, IRQ});
    apb(1'b1, IEN_ADDR, 8'h88);
    chk("irq", 0, {31'h0, IRQ});
    ev(5'h08);
    chk("irq", 1, {31'h0, IRQ});
    rd(STAT_ADDR, "stat", 8'h18);
    ev(5'h02);
    chk("lock", 0, {31'h0, CMD_LOCKED});
    chk("irq", 0, {31'h0, IRQ});
    rd(STAT_ADDR, "stat", 8'h00);
    ev(5'h04);
    rd(STAT_ADDR, "stat", 8'h10);
    ev(5'h01);
    rd(STAT_ADDR, "stat", 8'h00);
    @(posedge CLK);
    CE <= 1'b0;
    ev(5'h10);
    chk("frozen lock", 0, {31'h0, CMD_LOCKED});
    CE <= 1'b1;
    apb(1'b0, 32'h00000010, 8'h00);
    chk("slverr", 1, {31'h0, x});
    chk("unmapped", 0, r);
    summarize();
  end
endmodule
